//--- floppy_command_phase_decoder.sv
// Command, execution and result phase sequencer for floppy commands
// Operation
// R1 - Write data moves sector bytes from host to drive one by one during execution.
// R2 - Host gives opcode, drive/head byte, then C, H, R, N, final sector, gap and data length.
// R3 - A sector write ends with three status bytes and the four ID bytes.
// R4 - The deleted-data write uses the same sequence but marks sectors deleted.
// R5 - Format takes size, count, gap, filler, four ID bytes per sector, and returns 3 status plus 4 undefined.
// R6 - Recalibrate steps outward until track zero and then raises the interrupt.
// R7 - Seek steps the head until it sits over the new cylinder number.
// R8 - Sense interrupt status takes no parameters and answers status byte zero first.
// R9 - Its second result byte is the present cylinder number.
// R10 - Relative seek takes direction from opcode bit 6 and steps by the count in byte three.
// R11 - Specify is followed by step rate/head unload and head load/non-DMA bytes.
// R12 - Configure loads its fields into internal registers and returns no result bytes.
`timescale 1ns/1ps
module floppy_command_phase_decoder #(
  parameter int step_cycles = fdc_cmd_pkg::step_pulse_cycles
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Host byte stream in
  input wire logic [7:0] host_wdata,
  input wire logic host_wvalid,
  output logic host_wready,
  // Host byte stream out
  output logic [7:0] host_rdata,
  output logic host_rvalid,
  input wire logic host_rready,
  // Drive side
  input wire logic track_zero_pin,
  output fdc_cmd_pkg::drive_ctl_type drive_ctl,
  output logic [7:0] disk_data,
  output logic disk_data_valid,
  output logic deleted_mark,
  output logic format_active,
  output logic interrupt,
  // Loose status and settings
  output fdc_cmd_pkg::config_type config_out,
  output fdc_cmd_pkg::timing_type timing_out,
  output logic [7:0] present_cylinder_number
);

  typedef enum {st_opcode, st_params, st_exec_data, st_exec_id, st_step, st_result} state_type;
  state_type state_q;

  logic [7:0] opcode_q;
  logic [7:0] params_q [0:7];
  logic [3:0] index_q;
  logic [3:0] id_count_q;
  logic [7:0] sector_left_q;
  logic [7:0] steps_left_q;
  logic [7:0] target_q;
  logic seek_recal_q;
  logic dir_in_q;
  logic [2:0] result_left_q;
  logic [2:0] result_pos_q;
  logic [7:0] st0_q;
  logic [1:0] tz_sync_q;
  logic step_busy;
  logic step_wire;

  // Track zero arrives from the drive; two flops before use
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      tz_sync_q <= 2'b00;
    end else begin
      tz_sync_q <= {tz_sync_q[0], track_zero_pin};
    end
  end
  wire track_zero = tz_sync_q[1];

  // Opcode decode
  wire in_take = host_wvalid && host_wready;
  wire [4:0] op_low = host_wdata[4:0];
  wire is_write = (op_low == fdc_cmd_pkg::op_write_data) && !host_wdata[5];
  wire is_deleted = (op_low == fdc_cmd_pkg::op_write_deleted) && !host_wdata[5];
  wire is_format = (op_low == fdc_cmd_pkg::op_format_track) && !host_wdata[7] && !host_wdata[5];
  wire is_relseek = ({host_wdata[7], host_wdata[5:0]} == {1'b1, fdc_cmd_pkg::op_seek[5:0]});
  wire [3:0] need_params =
    (is_write || is_deleted) ? fdc_cmd_pkg::write_param_count :
    is_format ? fdc_cmd_pkg::format_param_count :
    (host_wdata == fdc_cmd_pkg::op_recalibrate) ? fdc_cmd_pkg::recal_param_count :
    (host_wdata == fdc_cmd_pkg::op_specify) ? fdc_cmd_pkg::specify_param_count :
    (host_wdata == fdc_cmd_pkg::op_seek || is_relseek) ? fdc_cmd_pkg::seek_param_count :
    (host_wdata == fdc_cmd_pkg::op_configure) ? fdc_cmd_pkg::configure_param_count : 4'h0;
  wire [3:0] param_total_d = need_params;
  logic [3:0] param_total_q;
  wire op_is_write = (opcode_q[4:0] == fdc_cmd_pkg::op_write_data) ||
                     (opcode_q[4:0] == fdc_cmd_pkg::op_write_deleted);
  wire op_is_format = (opcode_q[4:0] == fdc_cmd_pkg::op_format_track);
  wire op_is_relseek = opcode_q[7] && (opcode_q[5:0] == fdc_cmd_pkg::op_seek[5:0]);
  wire last_param = (index_q == param_total_q - 4'h1);
  // Specify carries settings in its first byte and configure ignores its first byte; neither is a drive
  wire has_drive_byte = (opcode_q != fdc_cmd_pkg::op_specify) && (opcode_q != fdc_cmd_pkg::op_configure);

  // Result byte selection
  wire [7:0] id_byte = params_q[3'(result_pos_q - 3'h2)];
  wire [7:0] result_byte =
    (opcode_q == fdc_cmd_pkg::op_version) ? fdc_cmd_pkg::version_answer :
    (opcode_q == fdc_cmd_pkg::op_sense_int) ?
      ((result_pos_q == 3'h0) ? st0_q : present_cylinder_number) : // see R8 see R9
    (result_pos_q == 3'h0) ? st0_q :
    (result_pos_q < 3'h3) ? fdc_cmd_pkg::normal_end_code :
    op_is_format ? 8'h00 : id_byte; // see R3 see R5

  assign host_wready = (state_q == st_opcode || state_q == st_params || state_q == st_exec_data ||
                        state_q == st_exec_id) && !host_rvalid;

  step_pulse_gen #(
    .pulse_cycles(step_cycles)
  ) stepper (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .fire((state_q == st_step) && !step_busy && steps_left_q != 8'h00 &&
          !(seek_recal_q && track_zero)),
    .busy(step_busy),
    .step_out(step_wire)
  );

  // Phase sequencer
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= st_opcode;
      opcode_q <= 8'h00;
      for (int i = 0; i < 8; i++) begin
        params_q[i] <= 8'h00;
      end
      index_q <= 4'h0;
      param_total_q <= 4'h0;
      id_count_q <= 4'h0;
      sector_left_q <= 8'h00;
      steps_left_q <= 8'h00;
      target_q <= 8'h00;
      seek_recal_q <= 1'b0;
      dir_in_q <= 1'b0;
      result_left_q <= 3'h0;
      result_pos_q <= 3'h0;
      st0_q <= fdc_cmd_pkg::invalid_answer;
      present_cylinder_number <= fdc_cmd_pkg::cylinder_reset;
      host_rdata <= 8'h00;
      host_rvalid <= 1'b0;
      disk_data <= 8'h00;
      disk_data_valid <= 1'b0;
      deleted_mark <= 1'b0;
      format_active <= 1'b0;
      interrupt <= 1'b0;
      config_out <= '{1'b0, 1'b0, 1'b0, fdc_cmd_pkg::fifo_threshold_reset, 8'h00};
      timing_out <= '0;
      drive_ctl <= '0;
    end else begin
      disk_data_valid <= 1'b0;
      drive_ctl.step <= step_wire;
      drive_ctl.direction_in <= dir_in_q;
      if (host_rvalid && host_rready) begin
        host_rvalid <= 1'b0;
      end
      unique case (state_q)
        st_opcode: begin
          if (in_take) begin
            opcode_q <= host_wdata;
            param_total_q <= param_total_d;
            index_q <= 4'h0;
            result_pos_q <= 3'h0;
            deleted_mark <= is_deleted; // see R4
            if (param_total_d != 4'h0) begin
              state_q <= st_params;
            end else begin
              // Sense, version and invalid answer right away
              if (host_wdata == fdc_cmd_pkg::op_sense_int) begin
                result_left_q <= fdc_cmd_pkg::sense_result_count; // see R8
                interrupt <= 1'b0;
              end else begin
                result_left_q <= fdc_cmd_pkg::one_result_count;
                if (host_wdata != fdc_cmd_pkg::op_version) begin
                  st0_q <= fdc_cmd_pkg::invalid_answer;
                end
              end
              state_q <= st_result;
            end
          end
        end
        st_params: begin
          if (in_take) begin
            params_q[index_q[2:0]] <= host_wdata; // see R2 see R11
            index_q <= index_q + 4'h1;
            if (index_q == 4'h0 && has_drive_byte) begin
              drive_ctl.head_select <= host_wdata[2];
              drive_ctl.drive_select <= host_wdata[1:0];
            end
            if (last_param) begin
              if (op_is_write) begin
                sector_left_q <= host_wdata; // see R1
                state_q <= st_exec_data;
              end else if (op_is_format) begin
                id_count_q <= 4'h0;
                sector_left_q <= params_q[2];
                format_active <= 1'b1;
                state_q <= st_exec_id; // see R5
              end else if (opcode_q == fdc_cmd_pkg::op_recalibrate) begin
                seek_recal_q <= 1'b1;
                dir_in_q <= 1'b0;
                steps_left_q <= 8'hff; // see R6
                target_q <= 8'h00;
                state_q <= st_step;
              end else if (opcode_q == fdc_cmd_pkg::op_specify) begin
                timing_out <= {params_q[0], host_wdata}; // see R11
                state_q <= st_opcode;
              end else if (opcode_q == fdc_cmd_pkg::op_configure) begin
                // No result phase for configure
                config_out.implied_seek_enable <= params_q[1][6]; // see R12
                config_out.fifo_disable <= params_q[1][5];
                config_out.polling_disable <= params_q[1][4];
                config_out.fifo_threshold <= params_q[1][3:0];
                config_out.precomp_start_track <= host_wdata;
                state_q <= st_opcode;
              end else if (op_is_relseek) begin
                seek_recal_q <= 1'b0;
                dir_in_q <= opcode_q[6]; // see R10
                steps_left_q <= host_wdata;
                target_q <= opcode_q[6] ? present_cylinder_number + host_wdata :
                                          present_cylinder_number - host_wdata;
                state_q <= st_step;
              end else begin
                seek_recal_q <= 1'b0;
                dir_in_q <= (host_wdata > present_cylinder_number); // see R7
                steps_left_q <= (host_wdata > present_cylinder_number) ?
                                host_wdata - present_cylinder_number : present_cylinder_number - host_wdata;
                target_q <= host_wdata;
                state_q <= st_step;
              end
            end
          end
        end
        st_exec_data: begin
          // Sector bytes forwarded one per host transfer
          if (in_take) begin
            disk_data <= host_wdata; // see R1
            disk_data_valid <= 1'b1;
            sector_left_q <= sector_left_q - 8'h01;
            if (sector_left_q <= 8'h01) begin
              st0_q <= {5'h00, params_q[0][2:0]};
              result_left_q <= fdc_cmd_pkg::write_result_count; // see R3
              state_q <= st_result;
            end
          end
        end
        st_exec_id: begin
          if (in_take) begin
            disk_data <= host_wdata;
            disk_data_valid <= 1'b1;
            id_count_q <= (id_count_q == fdc_cmd_pkg::format_id_count - 4'h1) ? 4'h0 : id_count_q + 4'h1;
            if (id_count_q == fdc_cmd_pkg::format_id_count - 4'h1) begin
              sector_left_q <= sector_left_q - 8'h01;
              if (sector_left_q <= 8'h01) begin
                format_active <= 1'b0;
                st0_q <= {5'h00, params_q[0][2:0]};
                result_left_q <= fdc_cmd_pkg::write_result_count; // see R5
                state_q <= st_result;
              end
            end
          end
        end
        st_step: begin
          // Stepper finishes its pulse before the cylinder count moves
          if (seek_recal_q && track_zero && !step_busy) begin
            present_cylinder_number <= 8'h00; // see R6
            st0_q <= fdc_cmd_pkg::seek_end_code | {6'h00, drive_ctl.drive_select};
            interrupt <= 1'b1;
            state_q <= st_opcode;
          end else if (steps_left_q == 8'h00 && !step_busy) begin
            present_cylinder_number <= target_q; // see R7 see R10
            st0_q <= fdc_cmd_pkg::seek_end_code | {6'h00, drive_ctl.drive_select};
            interrupt <= 1'b1;
            state_q <= st_opcode;
          end else if (step_wire && !drive_ctl.step) begin
            steps_left_q <= steps_left_q - 8'h01;
          end
        end
        st_result: begin
          if (!host_rvalid || host_rready) begin
            if (result_left_q != 3'h0) begin
              host_rdata <= result_byte;
              host_rvalid <= 1'b1;
              result_pos_q <= result_pos_q + 3'h1;
              result_left_q <= result_left_q - 3'h1;
            end else if (!host_rvalid || host_rready) begin
              state_q <= st_opcode;
            end
          end
        end
      endcase
    end
  end

endmodule

//--- fdc_cmd_pkg.sv
// Shared constants and types for the floppy command-phase decoder
package fdc_cmd_pkg;

  // Opcodes: write, deleted write and format as low five bits (upper bits carry flags), the rest as full bytes
  localparam logic [4:0] op_write_data = 5'h05;
  localparam logic [4:0] op_write_deleted = 5'h09;
  localparam logic [4:0] op_format_track = 5'h0d;
  localparam logic [7:0] op_recalibrate = 8'h07;
  localparam logic [7:0] op_sense_int = 8'h08;
  localparam logic [7:0] op_specify = 8'h03;
  localparam logic [7:0] op_seek = 8'h0f;
  localparam logic [7:0] op_configure = 8'h13;
  localparam logic [7:0] op_version = 8'h10;
  localparam logic [7:0] version_answer = 8'h90;
  localparam logic [7:0] invalid_answer = 8'h80;

  // Parameter byte counts after the opcode, and ID bytes per format sector
  localparam logic [3:0] write_param_count = 4'h8;
  localparam logic [3:0] format_param_count = 4'h5;
  localparam logic [3:0] recal_param_count = 4'h1;
  localparam logic [3:0] specify_param_count = 4'h2;
  localparam logic [3:0] seek_param_count = 4'h2;
  localparam logic [3:0] configure_param_count = 4'h3;
  localparam logic [3:0] format_id_count = 4'h4;

  // Result byte counts
  localparam logic [2:0] write_result_count = 3'h7;
  localparam logic [2:0] sense_result_count = 3'h2;
  localparam logic [2:0] one_result_count = 3'h1;

  // Status byte zero codes
  localparam logic [7:0] seek_end_code = 8'h20;
  localparam logic [7:0] normal_end_code = 8'h00;

  // Step pulse timing
  localparam int step_pulse_ns = 1000;
  localparam int clk_period_ns = 25;
  localparam int step_pulse_cycles = (step_pulse_ns + clk_period_ns - 1) / clk_period_ns;

  // Reset values
  localparam logic [7:0] cylinder_reset = 8'h00;
  localparam logic [3:0] fifo_threshold_reset = 4'h0;

  typedef enum logic [2:0] {
    kind_write,
    kind_format,
    kind_recal,
    kind_sense,
    kind_specify,
    kind_seek,
    kind_configure,
    kind_single
  } cmd_kind_type;

  // Drive-side step request and head/drive select
  typedef struct packed {
    logic step;
    logic direction_in;
    logic head_select;
    logic [1:0] drive_select;
  } drive_ctl_type;

  typedef struct packed {
    logic implied_seek_enable;
    logic fifo_disable;
    logic polling_disable;
    logic [3:0] fifo_threshold;
    logic [7:0] precomp_start_track;
  } config_type;

  typedef struct packed {
    logic [3:0] step_rate_time;
    logic [3:0] head_unload_time;
    logic [6:0] head_load_time;
    logic non_dma_flag;
  } timing_type;

endpackage

//--- step_pulse_gen.sv
// Head step pulse generator with fixed pulse width
`timescale 1ns/1ps
module step_pulse_gen #(
  parameter int pulse_cycles = fdc_cmd_pkg::step_pulse_cycles
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Request and status
  input wire logic fire,
  output logic busy,
  output logic step_out
);

  logic [7:0] count_q;
  logic [7:0] count_d;
  logic fire_ok;

  // A new pulse only starts after the last one fully ends
  assign fire_ok = fire && (count_q == 8'h00);
  assign count_d = fire_ok ? 8'(pulse_cycles) : (count_q != 8'h00) ? count_q - 8'h01 : 8'h00;
  assign busy = (count_q != 8'h00);

  // Pulse width counter
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      count_q <= 8'h00;
      step_out <= 1'b0;
    end else begin
      count_q <= count_d;
      step_out <= (count_d != 8'h00);
    end
  end

endmodule

//--- drive_model.sv
// Behavioural disk drive head with a track-zero sensor
`timescale 1ns/1ps
module drive_model (
  // Clock
  input wire logic sys_clk,
  // Control from the decoder
  input wire fdc_cmd_pkg::drive_ctl_type drive_ctl,
  // Sensor and head position
  output logic track_zero_pin,
  output int head_pos
);
  logic step_q = 1'b0;
  initial head_pos = 0;
  // One cylinder per rising step edge; the head cannot pass the outer stop
  always @(posedge sys_clk) begin
    step_q <= drive_ctl.step;
    if (drive_ctl.step && !step_q) begin
      head_pos <= drive_ctl.direction_in ? head_pos + 1 : (head_pos > 0 ? head_pos - 1 : 0);
    end
  end
  // Sensor high only over cylinder zero
  assign track_zero_pin = (head_pos == 0);
endmodule

//--- floppy_command_phase_decoder_props.sv
// Port-level properties of the floppy command decoder
`timescale 1ns/1ps
module fdc_cmd_props (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Host side
  input wire logic [7:0] host_wdata,
  input wire logic host_wvalid,
  input wire logic host_wready,
  input wire logic [7:0] host_rdata,
  input wire logic host_rvalid,
  input wire logic host_rready,
  // Drive side
  input wire logic track_zero_pin,
  input wire fdc_cmd_pkg::drive_ctl_type drive_ctl,
  input wire logic interrupt
);
  // ====================
  // Helper logic
  // Cycles the sensor has stood high, saturating
  logic [3:0] tz_q;
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) tz_q <= 4'h0;
    else tz_q <= !track_zero_pin ? 4'h0 : (tz_q == 4'hf ? tz_q : tz_q + 4'h1);
  end
  // ====================
  // Properties
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  a_result_holds: assert property (host_rvalid && !host_rready |=> host_rvalid && $stable(host_rdata))
    else $error("result byte changed before it was taken");
  a_no_take_result: assert property (host_rvalid |-> !host_wready)
    else $error("byte accepted while a result is pending");
  a_step_width: assert property ($rose(drive_ctl.step) |-> drive_ctl.step [*3])
    else $error("step pulse too short");
  a_step_ends: assert property ($rose(drive_ctl.step) |-> ##[1:12] !drive_ctl.step)
    else $error("step pulse never ended");
  a_dir_steady: assert property (drive_ctl.step && $past(drive_ctl.step) |-> $stable(drive_ctl.direction_in))
    else $error("direction moved during a step pulse");
  a_step_blocks: assert property (drive_ctl.step |-> !host_wready)
    else $error("bytes accepted while stepping");
  // Sync delay lets a few stale steps through, never a long run
  a_recal_stop: assert property ($rose(drive_ctl.step) && !drive_ctl.direction_in |-> tz_q < 4'h6)
    else $error("outward step while at track zero");
  a_int_clear: assert property (interrupt && host_wvalid && host_wready
    && host_wdata == fdc_cmd_pkg::op_sense_int |=> !interrupt)
    else $error("interrupt not cleared by sense");
  a_int_quiet: assert property ($rose(interrupt) |-> !drive_ctl.step)
    else $error("interrupt raised mid step");
endmodule

bind floppy_command_phase_decoder fdc_cmd_props chk (.sys_clk, .reset_n, .host_wdata, .host_wvalid, .host_wready,
  .host_rdata, .host_rvalid, .host_rready, .track_zero_pin, .drive_ctl, .interrupt);

//--- tb.sv
// Self-checking bench for the floppy command decoder
`timescale 1ns/1ps
module tb;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] host_wdata = 8'h00;
  logic host_wvalid = 1'b0;
  logic host_rready = 1'b0;
  logic host_wready, host_rvalid, track_zero_pin, disk_data_valid, deleted_mark, format_active, interrupt, del_seen;
  logic fa_seen;
  logic [7:0] host_rdata, disk_data, present_cylinder_number, a, b, r, op;
  logic [1:0] d;
  fdc_cmd_pkg::drive_ctl_type drive_ctl;
  fdc_cmd_pkg::config_type config_out;
  fdc_cmd_pkg::timing_type timing_out;
  int head_pos, i, j, k, n;
  int fails = 0;
  int n_compared = 0;
  int cycles = 0;
  int cyl = 0;
  logic [31:0] seed = 32'h1a89;
  logic [7:0] cq[$];
  logic [7:0] exp_q[$];
  logic [7:0] disk_q[$];

  floppy_command_phase_decoder #(.step_cycles(4)) uut (.sys_clk, .reset_n, .host_wdata, .host_wvalid, .host_wready,
    .host_rdata, .host_rvalid, .host_rready, .track_zero_pin, .drive_ctl, .disk_data, .disk_data_valid, .deleted_mark,
    .format_active, .interrupt, .config_out, .timing_out, .present_cylinder_number);
  drive_model drv (.sys_clk, .drive_ctl, .track_zero_pin, .head_pos);

  // ====================
  // Clock, disk capture and hang guard
  initial forever #12.5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cycles++;
    if (disk_data_valid === 1'b1) begin
      disk_q.push_back(disk_data);
      del_seen = deleted_mark;
    end
    // Sticky sighting of the format flag during a transfer
    if (format_active === 1'b1) fa_seen = 1'b1;
    if (cycles == 40000) begin
      fails++;
      results();
    end
  end

  // ====================
  // Helpers
  function logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task cmp(input string what, input logic [15:0] e, input logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, e, g);
    end
  endtask
  // Byte held until the edge that takes it
  task put(input logic [7:0] v);
    host_wdata <= v;
    host_wvalid <= 1'b1;
    @(negedge sys_clk);
    while (host_wready !== 1'b1) @(negedge sys_clk);
    @(posedge sys_clk);
  endtask
  // Drop strobes; a stale byte would otherwise start a new command
  task idle();
    host_wvalid <= 1'b0;
    host_rready <= 1'b0;
    @(posedge sys_clk);
  endtask
  task send();
    foreach (cq[q]) put(cq[q]);
    idle();
  endtask
  task get(output logic [7:0] v);
    host_rready <= 1'b1;
    @(negedge sys_clk);
    while (host_rvalid !== 1'b1) @(negedge sys_clk);
    v = host_rdata;
    @(posedge sys_clk);
  endtask
  // Wait for seek end, then read it back through sense
  task seek_end();
    i = 0;
    while (interrupt !== 1'b1 && i < 3000) begin
      @(posedge sys_clk);
      i++;
    end
    cmp("head", 16'(cyl), 16'(head_pos));
    cmp("select", 16'(d), 16'(drive_ctl.drive_select));
    cmp("pcn port", 16'(cyl), 16'(present_cylinder_number));
    cq = '{fdc_cmd_pkg::op_sense_int};
    send();
    get(r);
    cmp("st0", 16'(8'h20 | d), 16'(r));
    get(r);
    cmp("pcn", 16'(cyl), 16'(r));
    idle();
    cmp("interrupt", 16'h0, 16'(interrupt));
  endtask
  task results();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // ====================
  // Main sequence
  initial begin
    repeat (5) @(posedge sys_clk);
    reset_n <= 1'b1;
    @(posedge sys_clk);
    d = 2'(rnd());
    a = 8'(rnd());
    b = 8'(rnd());
    cq = '{8'h03, a, b};
    send();
    repeat (2) @(posedge sys_clk);
    cmp("timing", {a, b}, 16'(timing_out));
    a = 8'(rnd()) & 8'h7f;
    b = 8'(rnd());
    cq = '{8'h13, 8'h00, a, b};
    send();
    repeat (3) @(posedge sys_clk);
    cmp("config", {1'b0, a[6:0], b}, 16'(config_out));
    cmp("no result", 16'h0, 16'(host_rvalid));
    $display("test setup done");
    // Absolute, relative inward, relative outward, then recalibrate
    for (k = 0; k < 4; k++) begin
      n = (k == 2) ? 1 + rnd() % (cyl - 1) : 1 + rnd() % 20;
      op = (k == 0) ? 8'h0f : (k == 1) ? 8'hcf : 8'h8f;
      if (k == 3) cq = '{8'h07, 8'(d)};
      else cq = '{op, 8'(d), 8'(n)};
      cyl = (k == 0) ? n : (k == 1) ? cyl + n : (k == 2) ? cyl - n : 0;
      send();
      seek_end();
      $display("test seek %0d done", k);
    end
    // Write, deleted write, format
    for (k = 0; k < 3; k++) begin
      op = (k == 2) ? (8'h0d | (8'(rnd()) & 8'h40)) : ((k == 1 ? 8'h09 : 8'h05) | (8'(rnd()) & 8'hc0));
      cq = '{op, {5'h00, 1'(rnd()), d}};
      n = 1 + rnd() % 6;
      // Format: size, count, gap, filler; write: C, H, R, N, final sector, gap, length
      if (k == 2) begin
        cq.push_back(8'(rnd()));
        cq.push_back(8'(n));
        cq.push_back(8'(rnd()));
        cq.push_back(8'(rnd()));
      end else begin
        for (j = 0; j < 6; j++) cq.push_back(8'(rnd()));
        cq.push_back(8'(n));
      end
      n = (k == 2) ? n * 4 : n;
      exp_q = {};
      disk_q = {};
      del_seen = 1'b0;
      fa_seen = 1'b0;
      for (j = 0; j < n; j++) exp_q.push_back(8'(rnd()));
      foreach (exp_q[q]) cq.push_back(exp_q[q]);
      send();
      get(r);
      cmp("st0", 16'(fdc_cmd_pkg::normal_end_code | {5'h00, cq[1][2:0]}), 16'(r));
      for (j = 1; j < 7; j++) begin
        get(r);
        cmp("result", 16'((k < 2 && j > 2) ? cq[j - 1] : 8'h00), 16'(r));
      end
      idle();
      cmp("disk count", 16'(n), 16'(disk_q.size()));
      foreach (exp_q[q]) cmp("disk byte", 16'(exp_q[q]), 16'(disk_q[q]));
      cmp("deleted", 16'(k == 1), 16'(del_seen));
      cmp("format seen", 16'(k == 2), 16'(fa_seen));
      cmp("format end", 16'h0, 16'(format_active));
      cmp("head select", 16'(cq[1][2]), 16'(drive_ctl.head_select));
      $display("test transfer %0d done", k);
    end
    cq = '{8'h10};
    send();
    get(r);
    cmp("version", 16'h0090, 16'(r));
    idle();
    cq = '{8'h1f};
    send();
    get(r);
    cmp("invalid", 16'h0080, 16'(r));
    idle();
    $display("test single byte done");
    results();
  end
endmodule
